// File: rtl/dac_pkg.sv
// shared constants for the dual converter output control block
package dac_pkg;

  // ---------------------------------------------------------------
  // widths and pipeline shape
  // ---------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int PIPE_DEPTH = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 2 * CODE_W;
  localparam int SYNC_W = 5;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FIFO = 8'h08;
  localparam logic [7:0] OFS_RECOVERY = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CAPTURE = 0;
  localparam int CTRL_SOFT_PD = 1;
  localparam int ST_POWERED_DOWN = 0;
  localparam int ST_RECOVERING = 1;
  localparam int ST_FORMAT = 2;
  localparam int ST_FIRST_ON = 3;
  localparam int ST_SECOND_ON = 4;
  localparam int ST_FIFO_EMPTY = 5;
  localparam int ST_OVERRUN = 6;
  localparam int ST_SETTLING = 7;
  localparam int ST_CLK_STALL = 8;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] RECOVERY_RESET = 16'h0040;
  localparam logic [3:0] FORMAT_SETTLE = 4'h6;
  localparam int PCLK_PERIOD_NS = 20;
  localparam int MIN_SAMPLE_RATE_HZ = 100000;
  localparam int MAX_SAMPLE_PERIOD_NS = 1000000000 / MIN_SAMPLE_RATE_HZ;
  localparam int STALL_CYCLES = (MAX_SAMPLE_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

endpackage

// File: rtl/dac_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dac_fifo
  import dac_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // word to store
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  output logic [WIDTH-1:0] out_data, // oldest word
  output logic out_valid, // a word is held
  input wire logic out_ready // consumer takes the word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("dac_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty straight from the occupancy count
  assign in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; only words below the count are ever read
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers and occupancy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

// File: rtl/dac_pipe.sv
// fixed latency sample pipeline with valid tag and flush
`timescale 1ns/1ps
module dac_pipe
  import dac_pkg::*;
#(
  parameter int WIDTH = CODE_W,
  parameter int DEPTH = PIPE_DEPTH
)
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic advance, // one sample period elapsed
  input wire logic flush, // throw away every held sample
  input wire logic [WIDTH-1:0] din, // code entering the pipe
  input wire logic din_valid, // entering code is usable
  output logic [WIDTH-1:0] dout, // code leaving the pipe
  output logic dout_valid // leaving code is usable
);

  initial
  begin
    if (DEPTH < 1 || WIDTH < 1)
      $error("dac_pipe: DEPTH and WIDTH must be at least one");
  end

  logic [WIDTH-1:0] data_reg [DEPTH+1];
  logic [DEPTH:0] valid_reg;

  assign data_reg[0] = din;
  assign valid_reg[0] = din_valid;
  assign dout = data_reg[DEPTH];
  assign dout_valid = valid_reg[DEPTH];

  // one stage per sample period; a flush zeroes data and tags
  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++)
    begin : g_stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          data_reg[g] <= '0;
          valid_reg[g] <= 1'b0;
        end
        else if (flush)
        begin
          data_reg[g] <= '0;
          valid_reg[g] <= 1'b0;
        end
        else if (advance)
        begin
          data_reg[g] <= data_reg[g-1];
          valid_reg[g] <= valid_reg[g-1];
        end
      end
    end
  endgenerate

endmodule

// File: rtl/dac_ctrl.sv
// output control for a dual pipelined converter, with apb status and capture
//
// Behaviour
// - each converter takes a sample on every rising edge of the sample clock
// - enable low drives that converter's bus, enable high floats it
// - both converters keep converting whatever their enables say
// - power-down high holds a low-power state with no usable results
// - during power-down outputs are undefined and the pipeline contents are lost
// - format select low gives offset binary, high gives two's complement
// - samples are valid only while enable and power-down are both low
// - mid-scale is 800 offset binary, zero two's complement; only msb differs
`timescale 1ns/1ps
module dac_ctrl
  import dac_pkg::*;
#(
  parameter int WIDTH = CODE_W,
  parameter int LATENCY = PIPE_DEPTH,
  parameter int BUF_DEPTH = FIFO_DEPTH,
  parameter int STALL_LIMIT = STALL_CYCLES
)
(
  input wire logic pclk, // bus and logic clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic sample_clk, // sample clock pin
  input wire logic output_enable_first_n, // first bus enable pin, active low
  input wire logic output_enable_second_n, // second bus enable pin, active low
  input wire logic power_down_input, // power-down pin, active high
  input wire logic output_format_select, // format pin, high for two's complement
  input wire logic [WIDTH-1:0] core_first_code, // raw code of first core
  input wire logic [WIDTH-1:0] core_second_code, // raw code of second core
  output logic [WIDTH-1:0] data_first_out, // first output bus level
  output logic data_first_oe, // first bus driven when high
  output logic [WIDTH-1:0] data_second_out, // second output bus level
  output logic data_second_oe, // second bus driven when high
  output logic sample_first_valid, // first bus holds a usable sample
  output logic sample_second_valid, // second bus holds a usable sample
  output logic low_power // converter cores held in power-down
);

  initial
  begin
    if (WIDTH < 2 || WIDTH > 16 || LATENCY < 1 || BUF_DEPTH < 2 || STALL_LIMIT < 4)
      $error("dac_ctrl: unsupported parameter value");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic clk_last_reg;

  assign pin_raw = {output_format_select, power_down_input, output_enable_second_n,
                    output_enable_first_n, sample_clk};

  // first stage is read only by the second stage
  genvar s;
  generate
    for (s = 0; s < SYNC_W; s++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_reg[s] <= 1'b0;
          sync2_reg[s] <= 1'b0;
        end
        else
        begin
          sync1_reg[s] <= pin_raw[s];
          sync2_reg[s] <= sync1_reg[s];
        end
      end
    end
  endgenerate

  logic oe_first_n_s;
  logic oe_second_n_s;
  logic pd_pin_s;
  logic fmt_s;
  logic sample_strobe;

  assign oe_first_n_s = sync2_reg[1];
  assign oe_second_n_s = sync2_reg[2];
  assign pd_pin_s = sync2_reg[3];
  assign fmt_s = sync2_reg[4];

  // sample clock edge detect; a clock above half of pclk cannot be followed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_last_reg <= 1'b0;
    else
      clk_last_reg <= sync2_reg[0];
  end

  assign sample_strobe = sync2_reg[0] && !clk_last_reg;

  // ---------------------------------------------------------------
  // control register and power state
  // ---------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [15:0] recovery_reg;
  logic pd_active;

  assign pd_active = pd_pin_s || ctrl_reg[CTRL_SOFT_PD];
  assign low_power = pd_active;

  // power state machine
  typedef enum logic [1:0]
  {
    PS_RUN = 2'b00,
    PS_DOWN = 2'b01,
    PS_RECOVER = 2'b10
  } dac_pstate_t;

  dac_pstate_t pstate_reg;
  logic [15:0] rec_cnt_reg;

  // recovery counts sample periods, since the bypass charge is restored per clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pstate_reg <= PS_RUN;
      rec_cnt_reg <= '0;
    end
    else
    begin
      unique case (pstate_reg)
        PS_RUN:
        begin
          if (pd_active)
            pstate_reg <= PS_DOWN;
        end
        PS_DOWN:
        begin
          rec_cnt_reg <= recovery_reg;
          if (!pd_active)
            pstate_reg <= PS_RECOVER;
        end
        PS_RECOVER:
        begin
          if (pd_active)
            pstate_reg <= PS_DOWN;
          else if (rec_cnt_reg == '0)
            pstate_reg <= PS_RUN;
          else if (sample_strobe)
            rec_cnt_reg <= rec_cnt_reg - 1'b1;
        end
        default:
          pstate_reg <= PS_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sample clock watchdog and format settle
  // ---------------------------------------------------------------
  localparam int SW = $clog2(STALL_LIMIT + 1);
  logic [SW-1:0] stall_cnt_reg;
  logic clk_stalled;

  // a missing sample clock lets held charge decay, so the pipe is discarded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stall_cnt_reg <= '0;
    else if (sample_strobe)
      stall_cnt_reg <= '0;
    else if (stall_cnt_reg != SW'(STALL_LIMIT))
      stall_cnt_reg <= stall_cnt_reg + 1'b1;
  end

  assign clk_stalled = (stall_cnt_reg == SW'(STALL_LIMIT));

  logic fmt_last_reg;
  logic [3:0] settle_reg;

  // codes entering under the new format are tagged unusable until the old ones have drained
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_last_reg <= 1'b0;
      settle_reg <= '0;
    end
    else
    begin
      fmt_last_reg <= fmt_s;
      if (fmt_s != fmt_last_reg)
        settle_reg <= FORMAT_SETTLE;
      else if (sample_strobe && settle_reg != '0)
        settle_reg <= settle_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // conversion pipelines
  // ---------------------------------------------------------------
  // format is one inverted msb on the offset binary core code
  function automatic logic [WIDTH-1:0] apply_format(input logic [WIDTH-1:0] code,
                                                    input logic twos);
    apply_format = {code[WIDTH-1] ^ twos, code[WIDTH-2:0]};
  endfunction

  logic pipe_flush;
  logic in_valid;
  logic [WIDTH-1:0] first_q;
  logic [WIDTH-1:0] second_q;
  logic first_q_valid;
  logic second_q_valid;

  // power-down corrupts the pipeline; recovery samples enter tagged unusable
  assign pipe_flush = pd_active || clk_stalled;
  assign in_valid = (pstate_reg == PS_RUN) && (settle_reg == '0);

  // both run whatever the enables say
  dac_pipe #(.WIDTH(WIDTH), .DEPTH(LATENCY)) u_pipe_first
  (
    .pclk(pclk),
    .presetn(presetn),
    .advance(sample_strobe),
    .flush(pipe_flush),
    .din(apply_format(core_first_code, fmt_s)),
    .din_valid(in_valid),
    .dout(first_q),
    .dout_valid(first_q_valid)
  );

  dac_pipe #(.WIDTH(WIDTH), .DEPTH(LATENCY)) u_pipe_second
  (
    .pclk(pclk),
    .presetn(presetn),
    .advance(sample_strobe),
    .flush(pipe_flush),
    .din(apply_format(core_second_code, fmt_s)),
    .din_valid(in_valid),
    .dout(second_q),
    .dout_valid(second_q_valid)
  );

  // separate buses, each changing only on a sample strobe or a flush
  assign data_first_out = first_q;
  assign data_second_out = second_q;
  assign data_first_oe = !oe_first_n_s;
  assign data_second_oe = !oe_second_n_s;
  assign sample_first_valid = first_q_valid && !oe_first_n_s && !pd_active;
  assign sample_second_valid = second_q_valid && !oe_second_n_s && !pd_active;

  // ---------------------------------------------------------------
  // capture fifo for software readback
  // ---------------------------------------------------------------
  logic cap_valid;
  logic cap_ready;
  logic [FIFO_W-1:0] fifo_q;
  logic fifo_q_valid;
  logic fifo_pop;
  logic out_step_reg;
  logic overrun_reg;
  logic [31:0] count_reg;

  // a new output pair appears one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_step_reg <= 1'b0;
    else
      out_step_reg <= sample_strobe && !pipe_flush;
  end

  assign cap_valid = out_step_reg && ctrl_reg[CTRL_CAPTURE] && first_q_valid;

  dac_fifo #(.WIDTH(FIFO_W), .DEPTH(BUF_DEPTH)) u_fifo
  (
    .pclk(pclk),
    .presetn(presetn),
    .in_data({(CODE_W)'(second_q), (CODE_W)'(first_q)}),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .out_data(fifo_q),
    .out_valid(fifo_q_valid),
    .out_ready(fifo_pop)
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] status_word;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_FIFO) ||
               (paddr == OFS_RECOVERY) || (paddr == OFS_COUNT);
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc && !hit;
  assign fifo_pop = rd && (paddr == OFS_FIFO);

  // writable control state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RESET;
      recovery_reg <= RECOVERY_RESET;
    end
    else if (wr)
    begin
      if (paddr == OFS_CTRL)
        ctrl_reg <= pwdata[1:0];
      if (paddr == OFS_RECOVERY)
        recovery_reg <= pwdata[15:0];
    end
  end

  // overrun is sticky, cleared by writing one; a new drop in that cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_reg <= 1'b0;
    else if (cap_valid && !cap_ready)
      overrun_reg <= 1'b1;
    else if (wr && paddr == OFS_STATUS && pwdata[ST_OVERRUN])
      overrun_reg <= 1'b0;
  end

  // delivered sample counter, free running and wrapping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= '0;
    else if (out_step_reg && first_q_valid)
      count_reg <= count_reg + 1'b1;
  end

  always_comb
  begin
    status_word = '0;
    status_word[ST_POWERED_DOWN] = pd_active;
    status_word[ST_RECOVERING] = (pstate_reg == PS_RECOVER);
    status_word[ST_FORMAT] = fmt_s;
    status_word[ST_FIRST_ON] = !oe_first_n_s;
    status_word[ST_SECOND_ON] = !oe_second_n_s;
    status_word[ST_FIFO_EMPTY] = !fifo_q_valid;
    status_word[ST_OVERRUN] = overrun_reg;
    status_word[ST_SETTLING] = (settle_reg != '0);
    status_word[ST_CLK_STALL] = clk_stalled;
  end

  // read data is driven only in the access phase of a read
  always_comb
  begin
    prdata = '0;
    if (rd)
    begin
      unique case (paddr)
        OFS_CTRL: prdata = {30'h0, ctrl_reg};
        OFS_STATUS: prdata = status_word;
        OFS_FIFO: prdata = fifo_q_valid ? {8'h00, fifo_q} : 32'h0000_0000;
        OFS_RECOVERY: prdata = {16'h0000, recovery_reg};
        OFS_COUNT: prdata = count_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: dv/dac_ctrl_assertions.sv
// concurrent checks on the ports of the dual converter output control block
`timescale 1ns/1ps
module dac_ctrl_assertions
  import dac_pkg::*;
#(
  parameter int WIDTH = CODE_W
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic output_enable_first_n, // first enable pin
  input wire logic output_enable_second_n, // second enable pin
  input wire logic power_down_input, // power-down pin
  input wire logic [WIDTH-1:0] data_first_out, // first bus
  input wire logic data_first_oe, // first drive
  input wire logic [WIDTH-1:0] data_second_out, // second bus
  input wire logic data_second_oe, // second drive
  input wire logic sample_first_valid, // first usable
  input wire logic sample_second_valid, // second usable
  input wire logic low_power // cores powered down
);
  logic [1:0] up_reg;

  // edges since reset; pins need two edges through the synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // three edges of power-down leave nothing usable on either bus
  sequence s_held_down;
    low_power [*3];
  endsequence
  sequence s_quiet;
    !sample_first_valid && !sample_second_valid && data_first_out == '0 && data_second_out == '0;
  endsequence

  a_first_oe_follows:
    assert property (up_reg == 2'h3 |-> data_first_oe == !$past(output_enable_first_n, 2))
    else $error("first bus drive does not follow its pin");
  a_second_oe_follows:
    assert property (up_reg == 2'h3 |-> data_second_oe == !$past(output_enable_second_n, 2))
    else $error("second bus drive does not follow its pin");
  a_first_valid_gate:
    assert property (sample_first_valid |-> data_first_oe && !low_power)
    else $error("first sample valid while disabled or down");
  a_second_valid_gate:
    assert property (sample_second_valid |-> data_second_oe && !low_power)
    else $error("second sample valid while disabled or down");
  a_pd_enters_low:
    assert property (up_reg == 2'h3 && $past(power_down_input, 2) |-> low_power)
    else $error("power-down pin not followed");
  a_pd_flushes:
    assert property (s_held_down |-> s_quiet)
    else $error("buses not flushed in power-down");
  a_read_idle_zero:
    assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read access");
  a_zero_wait:
    assert property (psel && penable |-> pready)
    else $error("access phase not answered at once");
endmodule

bind dac_ctrl dac_ctrl_assertions #(.WIDTH(WIDTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .output_enable_first_n(output_enable_first_n),
  .output_enable_second_n(output_enable_second_n), .power_down_input(power_down_input),
  .data_first_out(data_first_out), .data_first_oe(data_first_oe),
  .data_second_out(data_second_out), .data_second_oe(data_second_oe),
  .sample_first_valid(sample_first_valid), .sample_second_valid(sample_second_valid),
  .low_power(low_power));

// File: dv/dac_capture_model.sv
// capture logic model that takes samples off the two output buses
`timescale 1ns/1ps
module dac_capture_model
  import dac_pkg::*;
(
  input wire logic pclk, // capture clock
  input wire logic presetn, // reset, active low
  input wire logic [CODE_W-1:0] data_first_out, // first bus level
  input wire logic data_first_oe, // first bus driven
  input wire logic [CODE_W-1:0] data_second_out, // second bus level
  input wire logic data_second_oe, // second bus driven
  input wire logic sample_first_valid, // first sample usable
  input wire logic sample_second_valid, // second sample usable
  output logic [CODE_W-1:0] seen_first, // last sample kept from first bus
  output logic [CODE_W-1:0] seen_second // last sample kept from second bus
);
  logic [CODE_W-1:0] wire_first, wire_second;

  // a floating bus shows the inverse of its last level, so it cannot match by luck
  assign wire_first = data_first_oe ? data_first_out : ~seen_first;
  assign wire_second = data_second_oe ? data_second_out : ~seen_second;

  // samples not tagged usable are dropped: bus disabled, power-down, stall flush, recovery and format settling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_first <= '0;
      seen_second <= '0;
    end
    else
    begin
      if (sample_first_valid)
        seen_first <= wire_first;
      if (sample_second_valid)
        seen_second <= wire_second;
    end
  end
endmodule

// File: dv/dac_ctrl_bench.sv
// self-checking bench for the dual converter output control block
`timescale 1ns/1ps
module dac_ctrl_bench;
  import dac_pkg::*;
  localparam int STALL = 16;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, sample_clk = 1'b0, sclk_q = 1'b0, run = 1'b1;
  logic oe1_n = 1'b0, oe2_n = 1'b0, pd = 1'b0, fmt = 1'b0, oe1, oe2, v1, v2, lp;
  logic [CODE_W-1:0] c1 = 12'h123, c2 = 12'hABC, d1, d2, s1, s2;
  logic [2:0] sdiv = 3'h0;
  int error_cnt = 0, n_tests = 0, k;

  always #(PCLK_PERIOD_NS / 2) pclk = ~pclk;

  // sample clock at an eighth of pclk, even duty, frozen when stopped
  always @(posedge pclk)
  begin
    sclk_q <= sample_clk;
    if (run)
    begin
      sdiv <= sdiv + 3'h1;
      sample_clk <= sdiv[2];
    end
  end

  dac_ctrl #(.STALL_LIMIT(STALL)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_clk(sample_clk), .output_enable_first_n(oe1_n), .output_enable_second_n(oe2_n),
    .power_down_input(pd), .output_format_select(fmt), .core_first_code(c1),
    .core_second_code(c2), .data_first_out(d1), .data_first_oe(oe1), .data_second_out(d2),
    .data_second_oe(oe2), .sample_first_valid(v1), .sample_second_valid(v2), .low_power(lp));
  dac_capture_model i_cap (
    .pclk(pclk), .presetn(presetn), .data_first_out(d1), .data_first_oe(oe1),
    .data_second_out(d2), .data_second_oe(oe2), .sample_first_valid(v1),
    .sample_second_valid(v2), .seen_first(s1), .seen_second(s2));

  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer; the answer is taken at the rising edge that samples pready high,
  // and the leading edge keeps a second call from re-raising psel in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wv();
    k = 0;
    while (v1 !== 1'b1 && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
  endtask

  task automatic done(input string nm);
    $display("test %s done, mismatches so far %0d", nm, error_cnt);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang ends the run as a failure
  initial
  begin
    cyc(20000);
    error_cnt++;
    summarize();
  end

  initial
  begin
    cyc(5);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", q, 32'(CTRL_RESET));
    apb(0, OFS_RECOVERY, 0);
    chk("recovery reset", q, 32'(RECOVERY_RESET));
    apb(0, 8'h14, 0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    done("registers");
    // count sample clocks until a new code shows on the first bus
    wv();
    @(posedge pclk);
    while (!(sample_clk && !sclk_q))
      @(posedge pclk);
    c1 <= 12'h800;
    k = 0;
    while (d1 !== 12'h800 && k < 20)
    begin
      @(posedge pclk);
      if (sample_clk && !sclk_q)
        k++;
    end
    chk("latency", k, 32'(PIPE_DEPTH - 1));
    chk("second bus", 32'(d2), 32'hABC);
    done("latency");
    fmt <= 1'b1;
    cyc(20);
    apb(0, OFS_STATUS, 0);
    chk("settling", 32'(q[ST_SETTLING]), 32'h1);
    cyc(180);
    wv();
    cyc(20);
    chk("mid scale", 32'(d1), 32'h000);
    chk("second fmt", 32'(d2), 32'h2BC);
    chk("model first", 32'(s1), 32'h000);
    apb(0, OFS_STATUS, 0);
    chk("status", q & 32'h1FF, b(ST_FORMAT) | b(ST_FIRST_ON) | b(ST_SECOND_ON) | b(ST_FIFO_EMPTY));
    done("format");
    oe2_n <= 1'b1;
    cyc(4);
    chk("oe2 off", 32'({oe2, v2, v1}), 32'h1);
    chk("model hold", 32'(s2), 32'h2BC);
    oe2_n <= 1'b0;
    cyc(4);
    chk("oe2 on", 32'({oe2, v2}), 32'h3);
    done("enable");
    apb(1, OFS_RECOVERY, 32'h3);
    pd <= 1'b1;
    run <= 1'b0;
    cyc(40);
    chk("low power", 32'({lp, v1, v2, d1, d2}), 32'h1 << 26);
    pd <= 1'b0;
    run <= 1'b1;
    cyc(4);
    apb(0, OFS_STATUS, 0);
    chk("recovering", q & 32'h3, b(ST_RECOVERING));
    wv();
    cyc(4);
    chk("after recovery", 32'(d1), 32'h000);
    done("power-down");
    run <= 1'b0;
    cyc(40);
    apb(0, OFS_STATUS, 0);
    chk("stall", 32'({q[ST_CLK_STALL], v1}), 32'h2);
    run <= 1'b1;
    wv();
    done("stall");
    apb(1, OFS_CTRL, b(CTRL_CAPTURE));
    cyc(100);
    apb(1, OFS_CTRL, 0);
    apb(0, OFS_STATUS, 0);
    chk("overrun", q & (b(ST_OVERRUN) | b(ST_FIFO_EMPTY)), b(ST_OVERRUN));
    repeat (FIFO_DEPTH)
    begin
      apb(0, OFS_FIFO, 0);
      chk("pair", q, 32'h002BC000);
    end
    apb(0, OFS_FIFO, 0);
    chk("empty pop", q, 32'h0);
    apb(1, OFS_STATUS, b(ST_OVERRUN));
    apb(0, OFS_STATUS, 0);
    chk("cleared", q & (b(ST_OVERRUN) | b(ST_FIFO_EMPTY)), b(ST_FIFO_EMPTY));
    done("fifo");
    // software power-down must look like the pin to the rest of the block
    apb(1, OFS_CTRL, b(CTRL_SOFT_PD));
    apb(0, OFS_STATUS, 0);
    chk("soft pd", 32'({lp, q[ST_POWERED_DOWN]}), 32'h3);
    done("soft power-down");
    summarize();
  end
endmodule
